// File: hdl/dhm_mem_if.sv
`timescale 1ns/1ps
module dhm_mem_if (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic PM_REQ,
  input wire logic PM_WRITE,
  input wire logic PM_USE_AGEN,
  input wire logic [23:0] PM_SEQ_ADDR,
  input wire logic [23:0] PM_AGEN_ADDR,
  input wire logic [47:0] PM_WDATA,
  input wire logic [1:0] PM_FMT,
  output logic [47:0] PM_RDATA,
  output logic PM_DONE,
  input wire logic DM_REQ,
  input wire logic DM_WRITE,
  input wire logic DM_USE_AGEN,
  input wire logic [31:0] DM_DIRECT_ADDR,
  input wire logic [31:0] DM_AGEN_ADDR,
  input wire logic [39:0] DM_WDATA,
  input wire logic [1:0] DM_FMT,
  output logic [39:0] DM_RDATA,
  output logic DM_DONE,
  output logic CORE_HALT,
  input wire logic [23:0] PM_BANK_BOUND,
  input wire logic [95:0] DM_BANK_BOUND,
  input wire logic [5:0] PM_WAIT_STATES,
  input wire logic [11:0] DM_WAIT_STATES,
  input wire logic [1:0] PM_ACK_USE,
  input wire logic [3:0] DM_ACK_USE,
  input wire logic [4:0] PM_PAGE_BITS,
  input wire logic [4:0] DM_PAGE_BITS,
  input wire logic [1:0] XFER_SEL,
  input wire logic [39:0] XFER_RF_DATA,
  output logic [47:0] XFER_REG,
  output logic [23:0] PROG_MEM_ADDR,
  input wire logic [47:0] PROG_MEM_BUS_IN,
  output logic [47:0] PROG_MEM_BUS_OUT,
  output logic PROG_MEM_BUS_OE,
  output logic [1:0] PROG_BANK_SELECT_N,
  output logic PROG_RD_N,
  output logic PROG_WR_N,
  output logic PROG_CTRL_OE,
  output logic PROG_PAGE_CROSS,
  input wire logic PROG_PORT_ACK,
  input wire logic PROG_PORT_FLOAT_N,
  output logic [31:0] DATA_MEM_ADDR,
  input wire logic [39:0] DATA_MEM_BUS_IN,
  output logic [39:0] DATA_MEM_BUS_OUT,
  output logic DATA_MEM_BUS_OE,
  output logic [3:0] DATA_BANK_SELECT_N,
  output logic DATA_RD_N,
  output logic DATA_WR_N,
  output logic DATA_CTRL_OE,
  output logic DATA_PAGE_CROSS,
  input wire logic DATA_PORT_ACK,
  input wire logic DATA_PORT_FLOAT_N,
  input wire logic BUS_REQUEST_N,
  output logic BUS_GRANT_N
);

  // ***********************************************************
  // decoders
  // ***********************************************************
  // bank index is the number of boundaries at or below the address
  function automatic logic [1:0] bank_of(input logic [31:0] a,
                                         input logic [95:0] b);
    bank_of = 2'({1'b0, a >= b[31:0]} + {1'b0, a >= b[63:32]}
                 + {1'b0, a >= b[95:64]});
  endfunction : bank_of

  function automatic logic [47:0] fmt_mask(input int p,
                                           input logic [1:0] f);
    if (p == dhm_pkg::PORT_PM) begin
      unique case (f)
        dhm_pkg::FMT_EXT: fmt_mask = dhm_pkg::PM_MASK_EXT;
        dhm_pkg::FMT_SGL: fmt_mask = dhm_pkg::PM_MASK_SGL;
        default: fmt_mask = dhm_pkg::PM_MASK_WIDE;
      endcase
    end else begin
      fmt_mask = (f == dhm_pkg::FMT_SGL) ? dhm_pkg::DM_MASK_SGL
                                          : dhm_pkg::DM_MASK_EXT;
    end
  endfunction : fmt_mask

  // ***********************************************************
  // per-port views of the two differently sized ports
  // ***********************************************************
  logic req [dhm_pkg::NPORT];
  logic req_wr [dhm_pkg::NPORT];
  logic [31:0] req_addr [dhm_pkg::NPORT];
  logic [47:0] req_wdata [dhm_pkg::NPORT];
  logic [1:0] req_fmt [dhm_pkg::NPORT];
  logic [95:0] bounds [dhm_pkg::NPORT];
  logic [11:0] waits [dhm_pkg::NPORT];
  logic [3:0] ack_use [dhm_pkg::NPORT];
  logic [4:0] page_bits [dhm_pkg::NPORT];
  logic [47:0] bus_pin [dhm_pkg::NPORT];
  logic ack_pin [dhm_pkg::NPORT];
  logic flt_pin_n [dhm_pkg::NPORT];
  logic [31:0] p_addr [dhm_pkg::NPORT];
  logic [47:0] p_wdata [dhm_pkg::NPORT];
  logic [47:0] p_rdata [dhm_pkg::NPORT];
  logic p_oe [dhm_pkg::NPORT];
  logic p_bus_oe [dhm_pkg::NPORT];
  logic [3:0] p_sel_n [dhm_pkg::NPORT];
  logic p_rd_n [dhm_pkg::NPORT];
  logic p_wr_n [dhm_pkg::NPORT];
  logic p_page [dhm_pkg::NPORT];
  logic p_done [dhm_pkg::NPORT];
  logic p_idle [dhm_pkg::NPORT];
  logic p_busy [dhm_pkg::NPORT];
  logic br_s1_reg;
  logic br_s2_reg;
  logic grant_reg;
  logic grant_next;
  logic bus_hold;
  logic [47:0] xfer_reg;
  logic [47:0] xfer_next;

  assign req[0] = PM_REQ;
  assign req[1] = DM_REQ;
  assign req_wr[0] = PM_WRITE;
  assign req_wr[1] = DM_WRITE;
  // program fetches use the sequencer, data reads the direct address, unless PM_USE_AGEN or DM_USE_AGEN picks a generator
  assign req_addr[0] = {8'h00, PM_USE_AGEN ? PM_AGEN_ADDR
                                           : PM_SEQ_ADDR};
  assign req_addr[1] = DM_USE_AGEN ? DM_AGEN_ADDR
                                   : DM_DIRECT_ADDR;
  assign req_wdata[0] = PM_WDATA;
  assign req_wdata[1] = {8'h00, DM_WDATA};
  assign req_fmt[0] = PM_FMT;
  assign req_fmt[1] = DM_FMT;
  // unused program boundaries sit at the top so only banks 0/1 decode
  assign bounds[0] = {32'hFFFF_FFFF, 32'hFFFF_FFFF, 8'h00,
                      PM_BANK_BOUND};
  assign bounds[1] = DM_BANK_BOUND;
  assign waits[0] = {6'h00, PM_WAIT_STATES};
  assign waits[1] = DM_WAIT_STATES;
  assign ack_use[0] = {2'h0, PM_ACK_USE};
  assign ack_use[1] = DM_ACK_USE;
  assign page_bits[0] = PM_PAGE_BITS;
  assign page_bits[1] = DM_PAGE_BITS;
  assign bus_pin[0] = PROG_MEM_BUS_IN;
  assign bus_pin[1] = {8'h00, DATA_MEM_BUS_IN};
  assign ack_pin[0] = PROG_PORT_ACK;
  assign ack_pin[1] = DATA_PORT_ACK;
  assign flt_pin_n[0] = PROG_PORT_FLOAT_N;
  assign flt_pin_n[1] = DATA_PORT_FLOAT_N;

  // ***********************************************************
  // bus request and grant
  // ***********************************************************
  // new accesses are refused as soon as a request is seen, so the
  // ports drain to idle before the grant goes out
  assign bus_hold = br_s2_reg | grant_reg;
  always_comb begin
    grant_next = br_s2_reg
                 & (grant_reg | (p_idle[0] & p_idle[1]));
  end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      br_s1_reg <= 1'b0;
      br_s2_reg <= 1'b0;
      grant_reg <= 1'b0;
    end else begin
      br_s1_reg <= ~BUS_REQUEST_N;
      br_s2_reg <= br_s1_reg;
      grant_reg <= grant_next;
    end
  end
  assign BUS_GRANT_N = ~grant_reg;
  assign CORE_HALT = bus_hold | p_busy[0] | p_busy[1];

  // ***********************************************************
  // one access engine per port
  // ***********************************************************
  for (genvar p = 0; p < dhm_pkg::NPORT; p++) begin : g_port
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic flt_s1_reg;
    logic flt_s2_reg;
    logic [47:0] bus_s1_reg;
    logic [47:0] bus_s2_reg;
    dhm_pkg::dhm_state_e st_reg;
    dhm_pkg::dhm_state_e st_next;
    logic [31:0] addr_reg;
    logic [31:0] addr_next;
    logic [31:0] page_reg;
    logic [31:0] page_next;
    logic page_x_reg;
    logic page_x_next;
    logic wr_reg;
    logic wr_next;
    logic [47:0] wdata_reg;
    logic [47:0] wdata_next;
    logic [47:0] mask_reg;
    logic [47:0] mask_next;
    logic [47:0] rdata_reg;
    logic [47:0] rdata_next;
    logic [1:0] bank_reg;
    logic [1:0] bank_next;
    logic [2:0] cnt_reg;
    logic [2:0] cnt_next;
    logic acku_reg;
    logic acku_next;
    logic done_reg;
    logic done_next;
    logic floated;
    logic start;
    logic [1:0] bank_new;

    // acknowledge, float and read data all take the same two-flop
    // path, so data is sampled in step with the acknowledge it rode on
    always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
        ack_s1_reg <= 1'b0;
        ack_s2_reg <= 1'b0;
        flt_s1_reg <= 1'b1;
        flt_s2_reg <= 1'b1;
        bus_s1_reg <= dhm_pkg::DATA_RST;
        bus_s2_reg <= dhm_pkg::DATA_RST;
      end else begin
        ack_s1_reg <= ack_pin[p];
        ack_s2_reg <= ack_s1_reg;
        flt_s1_reg <= flt_pin_n[p];
        flt_s2_reg <= flt_s1_reg;
        bus_s1_reg <= bus_pin[p];
        bus_s2_reg <= bus_s1_reg;
      end
    end

    assign floated = ~flt_s2_reg;
    assign start = req[p] & ~bus_hold & ~floated;
    assign bank_new = bank_of(req_addr[p], bounds[p]);

    always_comb begin
      st_next = st_reg;
      addr_next = addr_reg;
      page_next = page_reg;
      page_x_next = page_x_reg;
      wr_next = wr_reg;
      wdata_next = wdata_reg;
      mask_next = mask_reg;
      rdata_next = rdata_reg;
      bank_next = bank_reg;
      cnt_next = cnt_reg;
      acku_next = acku_reg;
      done_next = 1'b0;
      unique case (st_reg)
        dhm_pkg::ST_IDLE: begin
          if (start) begin
            st_next = dhm_pkg::ST_ACCESS;
            addr_next = req_addr[p];
            wr_next = req_wr[p];
            mask_next = fmt_mask(p, req_fmt[p]);
            wdata_next = req_wdata[p] & fmt_mask(p, req_fmt[p]);
            bank_next = bank_new;
            cnt_next = waits[p][3*bank_new +: 3];
            acku_next = ack_use[p][bank_new];
            // pins lag two flops, so a shorter read would see stale data
            if ((!req_wr[p] || acku_next)
                && cnt_next < dhm_pkg::CNT_SYNC) begin
              cnt_next = dhm_pkg::CNT_SYNC;
            end
            // dram row changes when bits above the page size differ
            page_x_next = ((req_addr[p] ^ page_reg) >> page_bits[p])
                          != 32'h0000_0000;
            page_next = req_addr[p];
          end
        end
        dhm_pkg::ST_ACCESS: begin
          if (floated) begin
            st_next = dhm_pkg::ST_FLOAT;
          end else if (cnt_reg != dhm_pkg::CNT_RST) begin
            cnt_next = cnt_reg - 3'h1;
          end else if (!acku_reg || ack_s2_reg) begin
            st_next = dhm_pkg::ST_IDLE;
            done_next = 1'b1;
            page_x_next = 1'b0;
            if (!wr_reg) begin
              rdata_next = bus_s2_reg & mask_reg;
            end
          end
        end
        dhm_pkg::ST_FLOAT: begin
          // the interrupted access is finished by the acknowledge that
          // the other party must give after the float is released
          if (!floated) begin
            st_next = dhm_pkg::ST_ACCESS;
            cnt_next = dhm_pkg::CNT_SYNC;
            acku_next = 1'b1;
          end
        end
        default: st_next = dhm_pkg::ST_IDLE;
      endcase
    end

    always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
        st_reg <= dhm_pkg::ST_IDLE;
        addr_reg <= dhm_pkg::ADDR_RST;
        page_reg <= dhm_pkg::ADDR_RST;
        page_x_reg <= 1'b0;
        wr_reg <= 1'b0;
        wdata_reg <= dhm_pkg::DATA_RST;
        mask_reg <= dhm_pkg::DATA_RST;
        rdata_reg <= dhm_pkg::DATA_RST;
        bank_reg <= 2'h0;
        cnt_reg <= dhm_pkg::CNT_RST;
        acku_reg <= 1'b0;
        done_reg <= 1'b0;
      end else begin
        st_reg <= st_next;
        addr_reg <= addr_next;
        page_reg <= page_next;
        page_x_reg <= page_x_next;
        wr_reg <= wr_next;
        wdata_reg <= wdata_next;
        mask_reg <= mask_next;
        rdata_reg <= rdata_next;
        bank_reg <= bank_next;
        cnt_reg <= cnt_next;
        acku_reg <= acku_next;
        done_reg <= done_next;
      end
    end

    assign p_idle[p] = st_reg == dhm_pkg::ST_IDLE;
    assign p_busy[p] = ~p_idle[p] | (req[p] & floated);
    assign p_oe[p] = ~grant_reg & ~floated;
    assign p_bus_oe[p] = p_oe[p] & wr_reg
                         & (st_reg == dhm_pkg::ST_ACCESS);
    assign p_sel_n[p] = (st_reg == dhm_pkg::ST_IDLE) ? dhm_pkg::SEL_IDLE
                        : ~(4'h1 << bank_reg);
    assign p_rd_n[p] = ~((st_reg == dhm_pkg::ST_ACCESS) & ~wr_reg);
    assign p_wr_n[p] = ~((st_reg == dhm_pkg::ST_ACCESS) & wr_reg);
    assign p_addr[p] = addr_reg;
    assign p_wdata[p] = wdata_reg;
    assign p_rdata[p] = rdata_reg;
    assign p_page[p] = page_x_reg;
    assign p_done[p] = done_reg;
  end

  // ***********************************************************
  // transfer register between the two buses
  // ***********************************************************
  always_comb begin
    unique case (XFER_SEL)
      dhm_pkg::XFER_FROM_PM: xfer_next = p_rdata[0];
      dhm_pkg::XFER_FROM_DM: xfer_next = {p_rdata[1][39:0], 8'h00};
      dhm_pkg::XFER_FROM_RF: xfer_next = {XFER_RF_DATA, 8'h00};
      default: xfer_next = xfer_reg;
    endcase
  end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      xfer_reg <= dhm_pkg::DATA_RST;
    end else begin
      xfer_reg <= xfer_next;
    end
  end
  assign XFER_REG = xfer_reg;

  // ***********************************************************
  // pins
  // ***********************************************************
  assign PM_RDATA = p_rdata[0];
  assign PM_DONE = p_done[0];
  assign DM_RDATA = p_rdata[1][39:0];
  assign DM_DONE = p_done[1];
  assign PROG_MEM_ADDR = p_addr[0][23:0];
  assign PROG_MEM_BUS_OUT = p_wdata[0];
  assign PROG_MEM_BUS_OE = p_bus_oe[0];
  assign PROG_BANK_SELECT_N = p_sel_n[0][1:0];
  assign PROG_RD_N = p_rd_n[0];
  assign PROG_WR_N = p_wr_n[0];
  assign PROG_CTRL_OE = p_oe[0];
  assign PROG_PAGE_CROSS = p_page[0];
  assign DATA_MEM_ADDR = p_addr[1];
  assign DATA_MEM_BUS_OUT = p_wdata[1][39:0];
  assign DATA_MEM_BUS_OE = p_bus_oe[1];
  assign DATA_BANK_SELECT_N = p_sel_n[1];
  assign DATA_RD_N = p_rd_n[1];
  assign DATA_WR_N = p_wr_n[1];
  assign DATA_CTRL_OE = p_oe[1];
  assign DATA_PAGE_CROSS = p_page[1];

endmodule : dhm_mem_if

// File: hdl/dhm_pkg.sv
package dhm_pkg;
  localparam int NPORT = 2;
  localparam int PORT_PM = 0;
  localparam int PORT_DM = 1;
  localparam int AW = 32;
  localparam int DW = 48;
  localparam int PM_AW = 24;
  localparam int DM_AW = 32;
  localparam int DM_DW = 40;
  localparam int WS_W = 3;
  localparam int NBANK = 4;
  localparam int PM_NBANK = 2;
  localparam int PG_W = 5;
  localparam logic [1:0] FMT_WIDE = 2'h0;
  localparam logic [1:0] FMT_EXT = 2'h1;
  localparam logic [1:0] FMT_SGL = 2'h2;
  localparam logic [47:0] PM_MASK_WIDE = 48'hFFFF_FFFF_FFFF;
  localparam logic [47:0] PM_MASK_EXT = 48'hFFFF_FFFF_FF00;
  localparam logic [47:0] PM_MASK_SGL = 48'hFFFF_FFFF_0000;
  localparam logic [47:0] DM_MASK_EXT = 48'h00FF_FFFF_FFFF;
  localparam logic [47:0] DM_MASK_SGL = 48'h00FF_FFFF_FF00;
  localparam logic [1:0] XFER_HOLD = 2'h0;
  localparam logic [1:0] XFER_FROM_PM = 2'h1;
  localparam logic [1:0] XFER_FROM_DM = 2'h2;
  localparam logic [1:0] XFER_FROM_RF = 2'h3;
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [47:0] DATA_RST = 48'h0000_0000_0000;
  localparam logic [2:0] CNT_RST = 3'h0;
  localparam logic [2:0] CNT_SYNC = 3'h2;
  localparam logic [3:0] SEL_IDLE = 4'hF;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCESS = 2'b01,
    ST_FLOAT = 2'b10
  } dhm_state_e;
endpackage : dhm_pkg

// File: testbench/dhm_port_model.sv
`timescale 1ns/1ps
// ****************
// external memory on one port
// ****************
module dhm_port_model #(
  parameter int AW = 24,
  parameter int DW = 48
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [AW-1:0] addr,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ctrl_oe,
  input wire logic bus_oe,
  input wire logic [DW-1:0] bus_out,
  input wire logic [3:0] ack_wait,
  output logic [DW-1:0] bus_in,
  output logic ack,
  output logic [DW-1:0] wr_data,
  output logic [AW-1:0] wr_addr
);
  logic [3:0] cnt;
  logic [DW-1:0] idle;
  logic act;
  assign act = !rd_n || !wr_n;
  // a slow part holds ack low for ack_wait strobe cycles, then high
  assign ack = !act || (cnt >= ack_wait);
  // a released bus shows the inverse of its last level, so it toggles between the last word read and its inverse
  assign bus_in = (!rd_n && ctrl_oe) ? DW'({~addr, addr}) : idle;
  always_ff @(posedge clk) begin
    if (rst) begin
      idle <= '0;
      cnt <= 4'h0;
    end else begin
      idle <= ~bus_in;
      cnt <= !act ? 4'h0 : (cnt == 4'hF) ? cnt : cnt + 4'h1;
    end
    if (!wr_n && bus_oe) begin
      wr_data <= bus_out;
      wr_addr <= addr;
    end
  end
endmodule : dhm_port_model

// File: testbench/dhm_props.sv
`timescale 1ns/1ps
// ****************
// port checker
// ****************
module dhm_props (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic BUS_REQUEST_N,
  input wire logic BUS_GRANT_N,
  input wire logic CORE_HALT,
  input wire logic PROG_CTRL_OE,
  input wire logic DATA_CTRL_OE,
  input wire logic PROG_MEM_BUS_OE,
  input wire logic DATA_MEM_BUS_OE,
  input wire logic PROG_RD_N,
  input wire logic [1:0] PROG_BANK_SELECT_N,
  input wire logic DATA_RD_N,
  input wire logic DATA_WR_N,
  input wire logic [3:0] DATA_BANK_SELECT_N,
  input wire logic DM_DONE,
  input wire logic DATA_PORT_FLOAT_N,
  input wire logic [11:0] DM_WAIT_STATES
);
  logic act;
  logic [1:0] bank;
  logic [7:0] cnt_reg, cnt_next;
  logic [2:0] ws_reg, ws_next;
  // strobe-low cycles and the wait count of the bank being accessed
  always_comb begin
    act = !DATA_RD_N || !DATA_WR_N;
    bank = !DATA_BANK_SELECT_N[3] ? 2'h3 :
           !DATA_BANK_SELECT_N[2] ? 2'h2 :
           !DATA_BANK_SELECT_N[1] ? 2'h1 : 2'h0;
    // saturate so a long acknowledge wait cannot wrap the count
    cnt_next = !act ? 8'h00 : (cnt_reg == 8'hFF) ? cnt_reg : cnt_reg + 8'h01;
    ws_next = act ? DM_WAIT_STATES[bank * 3 +: 3] : ws_reg;
  end
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cnt_reg <= 8'h00;
      ws_reg <= 3'h0;
    end else begin
      cnt_reg <= cnt_next;
      ws_reg <= ws_next;
    end
  end
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  sequence s_grant_quiet;
    BUS_GRANT_N [*3];
  endsequence
  sequence s_float_seen;
    !DATA_PORT_FLOAT_N [*4];
  endsequence
  AST_GRANT_LATE: assert property ($fell(BUS_REQUEST_N) && BUS_GRANT_N
    |-> s_grant_quiet) else $error("grant too early");
  AST_GRANT_FLOAT: assert property (!BUS_GRANT_N |-> !PROG_CTRL_OE &&
    !DATA_CTRL_OE && !PROG_MEM_BUS_OE && !DATA_MEM_BUS_OE)
    else $error("ports driven while granted");
  AST_GRANT_HALT: assert property (!BUS_GRANT_N |-> CORE_HALT)
    else $error("core runs while granted");
  AST_GRANT_HOLD: assert property (!BUS_GRANT_N && !BUS_REQUEST_N
    |=> !BUS_GRANT_N) else $error("grant dropped under request");
  AST_GRANT_FREE: assert property ($rose(BUS_REQUEST_N)
    |-> ##[1:4] BUS_GRANT_N) else $error("grant not released");
  AST_DM_SEL: assert property (act |-> $onehot(~DATA_BANK_SELECT_N))
    else $error("data select not one-hot");
  AST_PM_SEL: assert property (!PROG_RD_N
    |-> $onehot(~PROG_BANK_SELECT_N))
    else $error("program select not one-hot");
  AST_DM_WAIT: assert property (DM_DONE
    |-> cnt_reg >= {5'h00, ws_reg} + 8'h01) else $error("access too short");
  AST_DM_DONE_PULSE: assert property (DM_DONE |=> !DM_DONE)
    else $error("done longer than one cycle");
  AST_DM_FLOAT: assert property (s_float_seen |-> !DATA_CTRL_OE &&
    !DATA_MEM_BUS_OE) else $error("floated port still driven");
endmodule : dhm_props

bind dhm_mem_if dhm_props dhm_props_inst (
  .CLK_SYS(CLK_SYS), .RESET(RESET), .BUS_REQUEST_N(BUS_REQUEST_N),
  .BUS_GRANT_N(BUS_GRANT_N), .CORE_HALT(CORE_HALT),
  .PROG_CTRL_OE(PROG_CTRL_OE), .DATA_CTRL_OE(DATA_CTRL_OE),
  .PROG_MEM_BUS_OE(PROG_MEM_BUS_OE), .DATA_MEM_BUS_OE(DATA_MEM_BUS_OE),
  .PROG_RD_N(PROG_RD_N), .PROG_BANK_SELECT_N(PROG_BANK_SELECT_N),
  .DATA_RD_N(DATA_RD_N), .DATA_WR_N(DATA_WR_N),
  .DATA_BANK_SELECT_N(DATA_BANK_SELECT_N), .DM_DONE(DM_DONE),
  .DATA_PORT_FLOAT_N(DATA_PORT_FLOAT_N), .DM_WAIT_STATES(DM_WAIT_STATES));

// File: testbench/tb_dual_harvard_memory_interface.sv
`timescale 1ns/1ps
// ****************
// bench
// ****************
module tb_dual_harvard_memory_interface;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic PM_REQ = 1'b0, PM_WRITE = 1'b0, PM_USE_AGEN = 1'b0;
  logic DM_REQ = 1'b0, DM_WRITE = 1'b0, DM_USE_AGEN = 1'b0;
  logic [23:0] PM_SEQ_ADDR = '0, PM_AGEN_ADDR = '0, PROG_MEM_ADDR, pm_wa;
  logic [23:0] PM_BANK_BOUND = 24'h80_0000;
  logic [31:0] DM_DIRECT_ADDR = '0, DM_AGEN_ADDR = '0, DATA_MEM_ADDR, dm_wa;
  logic [95:0] DM_BANK_BOUND =
    {32'h0000_3000, 32'h0000_2000, 32'h0000_1000};
  logic [47:0] PM_WDATA = '0, PM_RDATA, XFER_REG, pm_wd, pm_last;
  logic [47:0] PROG_MEM_BUS_IN, PROG_MEM_BUS_OUT;
  logic [39:0] DM_WDATA = '0, XFER_RF_DATA = 40'h12_3456_789A;
  logic [39:0] DM_RDATA, DATA_MEM_BUS_IN, DATA_MEM_BUS_OUT, dm_wd;
  logic [1:0] PM_FMT = '0, DM_FMT = '0, XFER_SEL = '0, PM_ACK_USE = '0;
  logic [3:0] DM_ACK_USE = '0, pm_wait = '0, dm_wait = '0, sel_seen;
  logic [5:0] PM_WAIT_STATES = 6'h3A;
  logic [11:0] DM_WAIT_STATES = 12'hF58;
  logic [4:0] PM_PAGE_BITS = 5'h4, DM_PAGE_BITS = 5'h4;
  logic PROG_PORT_FLOAT_N = 1'b1, DATA_PORT_FLOAT_N = 1'b1;
  logic BUS_REQUEST_N = 1'b1, BUS_GRANT_N, PM_DONE, DM_DONE, CORE_HALT;
  logic PROG_MEM_BUS_OE, PROG_RD_N, PROG_WR_N, PROG_CTRL_OE, PROG_PAGE_CROSS;
  logic DATA_MEM_BUS_OE, DATA_RD_N, DATA_WR_N, DATA_CTRL_OE, DATA_PAGE_CROSS;
  logic PROG_PORT_ACK, DATA_PORT_ACK, pg_seen;
  logic [1:0] PROG_BANK_SELECT_N;
  logic [3:0] DATA_BANK_SELECT_N;
  int fail_count = 0, num_checks = 0, cyc, n;

  always #12.5 CLK_SYS = ~CLK_SYS;

  dhm_mem_if dhm_mem_if_inst (.*);
  dhm_port_model #(.AW(24), .DW(48)) dhm_port_model_inst (.clk(CLK_SYS),
    .rst(RESET), .addr(PROG_MEM_ADDR), .rd_n(PROG_RD_N), .wr_n(PROG_WR_N),
    .ctrl_oe(PROG_CTRL_OE), .bus_oe(PROG_MEM_BUS_OE), .ack_wait(pm_wait),
    .bus_out(PROG_MEM_BUS_OUT), .bus_in(PROG_MEM_BUS_IN),
    .ack(PROG_PORT_ACK), .wr_data(pm_wd), .wr_addr(pm_wa));
  dhm_port_model #(.AW(32), .DW(40)) dhm_port_model_inst_dm (.clk(CLK_SYS),
    .rst(RESET), .addr(DATA_MEM_ADDR), .rd_n(DATA_RD_N), .wr_n(DATA_WR_N),
    .ctrl_oe(DATA_CTRL_OE), .bus_oe(DATA_MEM_BUS_OE), .ack_wait(dm_wait),
    .bus_out(DATA_MEM_BUS_OUT), .bus_in(DATA_MEM_BUS_IN),
    .ack(DATA_PORT_ACK), .wr_data(dm_wd), .wr_addr(dm_wa));

  task automatic chk(input string what, input logic [47:0] e,
                     input logic [47:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic chk_cyc(input string what, input int lo, input int hi,
                         input int g);
    num_checks++;
    if (g < lo || g > hi) begin
      fail_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, g);
    end
  endtask : chk_cyc

  // bit 4 of the address picks the generator source, so both get used
  task automatic dm_op(input logic w, input logic [31:0] a,
                       input logic [39:0] d, input logic [1:0] f);
    @(negedge CLK_SYS);
    DM_REQ = 1'b1;
    DM_WRITE = w;
    DM_USE_AGEN = a[4];
    DM_AGEN_ADDR = a[4] ? a : ~a;
    DM_DIRECT_ADDR = a[4] ? ~a : a;
    DM_WDATA = d;
    DM_FMT = f;
    cyc = 0;
    while (DM_DONE !== 1'b1 && cyc < 60) begin
      @(negedge CLK_SYS);
      cyc++;
      if (cyc == 1) begin
        sel_seen = DATA_BANK_SELECT_N;
        pg_seen = DATA_PAGE_CROSS;
      end
    end
    DM_REQ = 1'b0;
  endtask : dm_op

  task automatic pm_op(input logic w, input logic [23:0] a,
                       input logic [47:0] d, input logic [1:0] f);
    @(negedge CLK_SYS);
    PM_REQ = 1'b1;
    PM_WRITE = w;
    PM_USE_AGEN = a[4];
    PM_AGEN_ADDR = a[4] ? a : ~a;
    PM_SEQ_ADDR = a[4] ? ~a : a;
    PM_WDATA = d;
    PM_FMT = f;
    cyc = 0;
    while (PM_DONE !== 1'b1 && cyc < 60) begin
      @(negedge CLK_SYS);
      cyc++;
      if (cyc == 1) begin
        sel_seen = {2'b11, PROG_BANK_SELECT_N};
        pg_seen = PROG_PAGE_CROSS;
      end
    end
    PM_REQ = 1'b0;
  endtask : pm_op

  task automatic wait_done;
    n = 0;
    while (DM_DONE !== 1'b1 && n < 20) begin
      @(negedge CLK_SYS);
      n++;
    end
    DM_REQ = 1'b0;
  endtask : wait_done

  task automatic t_dm;
    int ws [4] = '{0, 3, 5, 7};
    logic [31:0] a;
    logic [39:0] d;
    for (int b = 0; b < 4; b++) begin
      a = 32'(b) * 32'h0000_1010;
      d = 40'hA5_C3F0_0F1E + 40'(b);
      dm_op(1'b1, a, d, 2'(b % 3));
      chk_cyc("dm cycles", ws[b] + 2, ws[b] + 2, cyc);
      chk("dm select", 4'hF ^ (4'h1 << b), sel_seen);
      chk("dm addr", a, dm_wa);
      chk("dm data", b % 3 == 2 ? d & 40'hFF_FFFF_FF00 : d, dm_wd);
    end
  endtask : t_dm

  task automatic t_pm;
    logic [23:0] a [4] = '{24'h00_0010, 24'h80_0000, 24'hFF_FFF0, 24'h00_0020};
    logic [1:0] f [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
    logic [47:0] m [3] = '{dhm_pkg::PM_MASK_WIDE, dhm_pkg::PM_MASK_EXT,
                           dhm_pkg::PM_MASK_SGL};
    int ws;
    for (int i = 0; i < 4; i++) begin
      ws = a[i][23] ? 7 : 2;
      pm_op(i == 3, a[i], 48'hC3A5_5A3C_0FF0, f[i]);
      chk_cyc("pm cycles", ws + 2, ws + 2, cyc);
      chk("pm select", {2'b11, a[i][23] ? 2'b01 : 2'b10}, sel_seen);
      if (i == 3) begin
        chk("pm write", 48'hC3A5_5A3C_0FF0 & m[1], pm_wd);
        chk("pm addr", a[i], pm_wa);
      end else begin
        pm_last = {~a[i], a[i]} & m[i];
        chk("pm read", pm_last, PM_RDATA);
      end
    end
  endtask : t_pm

  task automatic t_xfer;
    logic [47:0] e [3];
    dm_op(1'b0, 32'h0000_2010, '0, 2'h0);
    e = '{pm_last, {8'hEF, 32'h0000_2010, 8'h00}, {XFER_RF_DATA, 8'h00}};
    chk("dm read", e[1][47:8], DM_RDATA);
    for (int i = 0; i < 3; i++) begin
      XFER_SEL = 2'(i + 1);
      @(negedge CLK_SYS);
      chk("xfer", e[i], XFER_REG);
    end
    XFER_SEL = 2'h0;
    @(negedge CLK_SYS);
    chk("xfer hold", e[2], XFER_REG);
  endtask : t_xfer

  task automatic t_ack_page;
    logic [31:0] a [3] = '{32'h0000_0040, 32'h0000_0044, 32'h0000_0050};
    DM_ACK_USE = 4'h2;
    dm_wait = 4'h8;
    dm_op(1'b1, 32'h0000_1000, 40'h11, 2'h0);
    chk_cyc("ack stretch", 11, 40, cyc);
    DM_ACK_USE = 4'h0;
    dm_op(1'b1, 32'h0000_1000, 40'h22, 2'h1);
    chk_cyc("ack unused", 5, 5, cyc);
    dm_wait = 4'h0;
    for (int i = 0; i < 3; i++) begin
      dm_op(1'b0, a[i], '0, 2'h0);
      chk("dm page", i != 1, pg_seen);
    end
    pm_op(1'b0, 24'h00_0030, '0, 2'h0);
    chk("pm page", 1'b1, pg_seen);
  endtask : t_ack_page

  task automatic t_bus;
    @(negedge CLK_SYS);
    BUS_REQUEST_N = 1'b0;
    n = 0;
    while (BUS_GRANT_N !== 1'b0 && n < 12) begin
      @(negedge CLK_SYS);
      n++;
    end
    chk_cyc("grant delay", 3, 11, n);
    chk("granted", 5'h01, {PROG_CTRL_OE, DATA_CTRL_OE, PROG_MEM_BUS_OE,
      DATA_MEM_BUS_OE, CORE_HALT});
    DM_DIRECT_ADDR = '0;
    DM_USE_AGEN = 1'b0;
    DM_WRITE = 1'b0;
    DM_REQ = 1'b1;
    repeat (6) @(negedge CLK_SYS);
    chk("held grant", 2'b00, {BUS_GRANT_N, DM_DONE});
    BUS_REQUEST_N = 1'b1;
    wait_done;
    chk_cyc("resume", 3, 19, n);
    chk("grant off", 1'b1, BUS_GRANT_N);
  endtask : t_bus

  task automatic t_float;
    @(negedge CLK_SYS);
    DATA_PORT_FLOAT_N = 1'b0;
    repeat (4) @(negedge CLK_SYS);
    chk("float oe", 2'b01, {DATA_CTRL_OE, PROG_CTRL_OE});
    pm_op(1'b0, 24'h00_0010, '0, 2'h0);
    chk_cyc("pm beside float", 4, 4, cyc);
    DM_REQ = 1'b1;
    repeat (6) @(negedge CLK_SYS);
    chk("floated port", 2'b10, {CORE_HALT, DM_DONE});
    DATA_PORT_FLOAT_N = 1'b1;
    wait_done;
    chk_cyc("float release", 1, 19, n);
    // a program read frozen by its float must finish with fresh data
    PM_SEQ_ADDR = 24'h80_0000;
    PM_USE_AGEN = 1'b0;
    PM_WRITE = 1'b0;
    PM_FMT = 2'h0;
    PM_REQ = 1'b1;
    repeat (2) @(negedge CLK_SYS);
    PROG_PORT_FLOAT_N = 1'b0;
    repeat (8) @(negedge CLK_SYS);
    chk("pm frozen", 3'b100, {CORE_HALT, PM_DONE, PROG_CTRL_OE});
    PROG_PORT_FLOAT_N = 1'b1;
    n = 0;
    while (PM_DONE !== 1'b1 && n < 20) begin
      @(negedge CLK_SYS);
      n++;
    end
    PM_REQ = 1'b0;
    chk("pm resumed", {24'h7F_FFFF, 24'h80_0000}, PM_RDATA);
  endtask : t_float

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (5) @(negedge CLK_SYS);
    RESET = 1'b0;
    @(negedge CLK_SYS);
    chk("idle pins", 17'h1_FC3F, {PROG_RD_N, PROG_WR_N, DATA_RD_N, DATA_WR_N,
      BUS_GRANT_N, PROG_CTRL_OE, DATA_CTRL_OE, PROG_MEM_BUS_OE,
      DATA_MEM_BUS_OE, DM_DONE, PM_DONE, PROG_BANK_SELECT_N,
      DATA_BANK_SELECT_N});
    t_dm;
    t_pm;
    t_xfer;
    t_ack_page;
    t_bus;
    t_float;
    final_report;
  end

  // the run needs well under a thousand cycles
  initial begin
    #(25 * 4000);
    fail_count++;
    final_report;
  end
endmodule : tb_dual_harvard_memory_interface
